// ==== rtl/mseb_bridge.sv ====
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "mseb_defines.svh"
module mseb_bridge (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output wire logic        mdio_o,
  output wire logic        mdio_oe,
  output wire logic        ee_req,
  output wire logic        ee_write,
  output wire logic [15:0] ee_addr,
  output wire logic [7:0]  ee_wdata,
  input  wire logic        ee_done,
  input  wire logic [7:0]  ee_rdata,
  input  wire logic        ee_internal_busy,
  input  wire logic        eeprom_present
);

  mseb_pkg::mseb_state_t st_reg;
  mseb_pkg::mseb_state_t st_next;
  logic [4:0]  cnt_reg;
  logic [15:0] shf_reg;
  logic [4:0]  rad_reg;
  logic        mdo_reg;
  logic        oe_reg;
  logic        mdc_d_reg;
  logic [1:0]  mmd_fn_reg;
  logic [4:0]  mmd_dev_reg;
  logic [15:0] mmd_addr_reg;
  logic [7:0]  ee_byte_reg;
  logic        ee_wr_reg;
  logic [4:0]  phyad_reg;
  logic [15:0] frames_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [1:0]  line_s;
  logic        ee_busy;
  logic [7:0]  ee_rd_byte;
  logic        ee_rd_valid;

  // mdc is only an input here; both pins cross through two flops
  mseb_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({mdc, mdio_i}),
    .q       (line_s)
  );

  wire mdc_s  = line_s[1];
  wire mdio_s = line_s[0];
  wire rise   = mdc_s & ~mdc_d_reg;

  // state decode
  wire is_hdr   = st_reg == mseb_pkg::S_HDR;
  wire is_ta1   = st_reg == mseb_pkg::S_TA1;
  wire is_ta2   = st_reg == mseb_pkg::S_TA2;
  wire is_rdata = st_reg == mseb_pkg::S_RDATA;
  wire is_wdata = st_reg == mseb_pkg::S_WDATA;

  // header fields as the last header bit arrives
  wire [11:0] hdr_full = {shf_reg[10:0], mdio_s};
  wire        for_us   = hdr_full[`MSEB_HF_PHY] == phyad_reg;
  wire        rd_us    = for_us && hdr_full[`MSEB_HF_OP] == `MSEB_OP_RD;
  wire        wr_us    = for_us && hdr_full[`MSEB_HF_OP] == `MSEB_OP_WR;
  wire        hdr_done = rise && is_hdr && cnt_reg == `MSEB_HDR_LAST;
  wire        rd_hit   = hdr_done && rd_us;
  wire        wr_done  = rise && is_wdata && cnt_reg == `MSEB_WR_LAST;
  wire [15:0] wdata16  = {shf_reg[14:0], mdio_s};
  wire [4:0]  rad_now  = hdr_full[`MSEB_HF_REG];

  // indirect mmd decode
  wire fn_addr = mmd_fn_reg == `MSEB_FN_ADDR;
  wire ee_dev  = mmd_dev_reg == `MSEB_EE_DEVAD;
  wire wr_ctl  = wr_done && rad_reg == `MSEB_RA_MMDCTL;
  wire wr_ad   = wr_done && rad_reg == `MSEB_RA_MMDAD;
  wire wr_eec  = wr_done && rad_reg == `MSEB_RA_EECTL;
  wire rd_ad   = rd_hit && rad_now == `MSEB_RA_MMDAD;
  wire ad_inc  = (wr_ad && mmd_fn_reg[1]) || (rd_ad && mmd_fn_reg == `MSEB_FN_INC_RW);
  wire ee_start = wr_eec && wdata16[`MSEB_EEC_GO];

  // read word for the addressed register
  wire [15:0] mmd_word = fn_addr ? mmd_addr_reg : ee_dev ? {8'h00, ee_byte_reg} : 16'h0000;
  wire [15:0] rd_word  =
    (rad_now == `MSEB_RA_MMDCTL) ? {mmd_fn_reg, 9'h000, mmd_dev_reg} :
    (rad_now == `MSEB_RA_MMDAD)  ? mmd_word :
    (rad_now == `MSEB_RA_EECTL)  ? {ee_busy, eeprom_present, 13'h0000, ee_wr_reg} :
    16'h0000;

  // frame sequencer; a zero in idle is taken as the first start bit
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      mseb_pkg::S_IDLE:  if (rise && !mdio_s) st_next = mseb_pkg::S_ST1;
      mseb_pkg::S_ST1:   if (rise && mdio_s) st_next = mseb_pkg::S_HDR;
      mseb_pkg::S_HDR: begin
        if (hdr_done)
          st_next = rd_us ? mseb_pkg::S_TA1 : wr_us ? mseb_pkg::S_WDATA : mseb_pkg::S_SKIP;
      end
      mseb_pkg::S_TA1:   if (rise) st_next = mseb_pkg::S_TA2;
      mseb_pkg::S_TA2:   if (rise) st_next = mseb_pkg::S_RDATA;
      mseb_pkg::S_RDATA: if (rise && cnt_reg == `MSEB_RD_LAST) st_next = mseb_pkg::S_IDLE;
      mseb_pkg::S_WDATA,
      mseb_pkg::S_SKIP:  if (rise && cnt_reg == `MSEB_WR_LAST) st_next = mseb_pkg::S_IDLE;
      default:           st_next = mseb_pkg::S_IDLE;
    endcase
  end

  // shifting only on sampled rising edges of mdc
  wire [4:0] cnt_next = (st_next != st_reg) ? 5'h00 : rise ? cnt_reg + 5'h01 : cnt_reg;
  wire [15:0] shf_next =
    !rise                ? shf_reg :
    rd_hit               ? rd_word :
    (is_hdr || is_wdata) ? wdata16 :
    (is_ta2 || is_rdata) ? {shf_reg[14:0], 1'b0} :
    shf_reg;
  // zero for second turnaround bit, then msb first
  wire mdo_next = !rise ? mdo_reg : is_ta1 ? 1'b0 : (is_ta2 || is_rdata) ? shf_reg[15] : 1'b1;
  wire oe_next  = st_next == mseb_pkg::S_TA2 || st_next == mseb_pkg::S_RDATA;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg    <= mseb_pkg::S_IDLE;
      cnt_reg   <= 5'h00;
      shf_reg   <= 16'h0000;
      mdo_reg   <= 1'b1;
      oe_reg    <= 1'b0;
      mdc_d_reg <= 1'b1;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      shf_reg   <= shf_next;
      mdo_reg   <= mdo_next;
      oe_reg    <= oe_next;
      mdc_d_reg <= mdc_s;
    end
  end

  // address of the frame in flight, also shown in the status word
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rad_reg <= 5'h00;
    else if (hdr_done && for_us)
      rad_reg <= rad_now;
  end

  // mmd registers; a completed eeprom read outranks a data write
  wire [15:0] addr_next = (wr_ad && fn_addr) ? wdata16 :
                          ad_inc ? mmd_addr_reg + 16'h0001 : mmd_addr_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mmd_fn_reg   <= `MSEB_FN_ADDR;
      mmd_dev_reg  <= 5'h00;
      mmd_addr_reg <= 16'h0000;
      ee_byte_reg  <= 8'h00;
      ee_wr_reg    <= 1'b0;
    end else begin
      mmd_addr_reg <= addr_next;
      if (wr_ctl) begin
        mmd_fn_reg  <= wdata16[`MSEB_MC_FN];
        mmd_dev_reg <= wdata16[`MSEB_MC_DEV];
      end
      if (ee_rd_valid)
        ee_byte_reg <= ee_rd_byte;
      else if (wr_ad && !fn_addr && ee_dev)
        ee_byte_reg <= wdata16[7:0];
      if (ee_start && !ee_busy)
        ee_wr_reg <= wdata16[`MSEB_EEC_WR];
    end
  end

  // byte-wide request engine with execute/busy tracking
  mseb_ee_hs u_hs (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .start            (ee_start),
    .start_wr         (wdata16[`MSEB_EEC_WR]),
    .start_addr       (mmd_addr_reg),
    .start_data       (ee_byte_reg),
    .ee_internal_busy (ee_internal_busy),
    .ee_done          (ee_done),
    .ee_rdata         (ee_rdata),
    .ee_req           (ee_req),
    .ee_write         (ee_write),
    .ee_addr          (ee_addr),
    .ee_wdata         (ee_wdata),
    .busy             (ee_busy),
    .rd_byte          (ee_rd_byte),
    .rd_valid         (ee_rd_valid)
  );

  // counts frames carrying our phy address and a valid opcode
  always_ff @(posedge aclk) begin
    if (!aresetn)
      frames_reg <= 16'h0000;
    else if (hdr_done && (rd_us || wr_us))
      frames_reg <= frames_reg + 16'h0001;
  end

  // axi4-lite: one write and one read at a time
  function automatic logic mapped(input logic [31:0] a);
    mapped = a == `MSEB_AX_CTRL || a == `MSEB_AX_STAT || a == `MSEB_AX_FRMS;
  endfunction

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire do_wr   = aw_got_reg && w_got_reg;
  wire [31:0] stat_word = {19'h00000, rad_reg, 5'h00, st_reg != mseb_pkg::S_IDLE,
                           eeprom_present, ee_busy};
  wire [31:0] ax_rd = (s_axi_araddr == `MSEB_AX_CTRL) ? {27'h0000000, phyad_reg} :
                      (s_axi_araddr == `MSEB_AX_STAT) ? stat_word :
                      (s_axi_araddr == `MSEB_AX_FRMS) ? {16'h0000, frames_reg} : 32'h0000_0000;

  // write address and data are latched independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg  <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
    end else begin
      aw_got_reg <= !do_wr && (aw_got_reg || aw_fire);
      w_got_reg  <= !do_wr && (w_got_reg || w_fire);
      if (aw_fire) awaddr_reg <= s_axi_awaddr;
      if (w_fire) begin
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
    end
  end

  // register update and responses; unmapped addresses get slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phyad_reg  <= `MSEB_PHYAD_RST;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `MSEB_RESP_OK;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `MSEB_RESP_OK;
    end else begin
      if (do_wr && awaddr_reg == `MSEB_AX_CTRL && wstrb0_reg)
        phyad_reg <= wdata_reg[4:0];
      bvalid_reg <= do_wr || (bvalid_reg && !s_axi_bready);
      if (do_wr) bresp_reg <= mapped(awaddr_reg) ? `MSEB_RESP_OK : `MSEB_RESP_ERR;
      rvalid_reg <= ar_fire || (rvalid_reg && !s_axi_rready);
      if (ar_fire) begin
        rdata_reg <= ax_rd;
        rresp_reg <= mapped(s_axi_araddr) ? `MSEB_RESP_OK : `MSEB_RESP_ERR;
      end
    end
  end

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign mdio_o        = mdo_reg;
  assign mdio_oe       = oe_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  oe_window_a: assert property (mdio_oe |-> is_ta2 || is_rdata)
    else $error("driver on outside read return");
  idle_float_a: assert property (st_reg == mseb_pkg::S_IDLE |-> !mdio_oe)
    else $error("driver on while idle");
  ta_levels_a: assert property ((is_ta1 |-> !mdio_oe) and (is_ta2 |-> !mdio_o))
    else $error("turnaround levels wrong");
  start_seen_a: assert property ($rose(is_hdr) |->
    $past(mdio_s) && $past(st_reg) == mseb_pkg::S_ST1)
    else $error("frame began without 01");
  read_match_a: assert property ($rose(is_ta1) |->
    $past(hdr_full[`MSEB_HF_PHY]) == phyad_reg && $past(hdr_full[`MSEB_HF_OP]) == `MSEB_OP_RD)
    else $error("read answered for wrong phy or opcode");
  msb_first_a: assert property (rise && is_ta2 |=>
    mdio_o == $past(shf_reg[15]) ##1 $stable(mdio_o))
    else $error("read data not msb first");
  sample_rise_a: assert property (is_hdr && !rise |=> $stable(shf_reg))
    else $error("shift without mdc rising edge");
  ee_launch_a: assert property (ee_start && !ee_busy |=>
    ee_req && ee_addr == $past(mmd_addr_reg))
    else $error("eeprom op not launched");
  ee_dev_only_a: assert property ($changed(ee_byte_reg) |->
    $past(ee_dev) || $past(ee_rd_valid))
    else $error("eeprom byte changed off device 1E");
  present_a: assert property (ar_fire && s_axi_araddr == `MSEB_AX_STAT |=>
    s_axi_rdata[1] == $past(eeprom_present))
    else $error("present flag misreported");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  rd_frame_c: cover property (rise && is_rdata && cnt_reg == `MSEB_RD_LAST);
  wr_frame_c: cover property (wr_done && rad_reg == `MSEB_RA_EECTL);
  skip_c:     cover property (st_reg == mseb_pkg::S_SKIP);

endmodule

// ==== rtl/mseb_defines.svh ====
`ifndef MSEB_DEFINES_SVH
`define MSEB_DEFINES_SVH

// management frame opcodes
`define MSEB_OP_RD      2'h2
`define MSEB_OP_WR      2'h1

// header field slices of the 12 bits after the start field
`define MSEB_HF_OP      11:10
`define MSEB_HF_PHY     9:5
`define MSEB_HF_REG     4:0

// bit counter end values per frame section
`define MSEB_HDR_LAST   5'h0B
`define MSEB_RD_LAST    5'h0F
`define MSEB_WR_LAST    5'h11

// direct register addresses
`define MSEB_RA_MMDCTL  5'h0D
`define MSEB_RA_MMDAD   5'h0E
`define MSEB_RA_EECTL   5'h10

// mmd control fields and functions
`define MSEB_MC_FN      15:14
`define MSEB_MC_DEV     4:0
`define MSEB_FN_ADDR    2'h0
`define MSEB_FN_INC_RW  2'h2
`define MSEB_EE_DEVAD   5'h1E

// eeprom control register bits
`define MSEB_EEC_GO     15
`define MSEB_EEC_DET    14
`define MSEB_EEC_WR     0

// axi4-lite map, reset values and responses
`define MSEB_AX_CTRL    32'h0000_0000
`define MSEB_AX_STAT    32'h0000_0004
`define MSEB_AX_FRMS    32'h0000_0008
`define MSEB_PHYAD_RST  5'h00
`define MSEB_RESP_OK    2'h0
`define MSEB_RESP_ERR   2'h2
`define MSEB_LINE_IDLE  2'h3

`endif

// ==== rtl/mseb_pkg.sv ====
package mseb_pkg;

  // frame decoder states, one-hot
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_ST1   = 8'h02,
    S_HDR   = 8'h04,
    S_TA1   = 8'h08,
    S_TA2   = 8'h10,
    S_RDATA = 8'h20,
    S_WDATA = 8'h40,
    S_SKIP  = 8'h80
  } mseb_state_t;

endpackage

// ==== rtl/mseb_sync.sv ====
`timescale 1ns/10ps
`include "mseb_defines.svh"

module mseb_sync (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] d,
  output wire logic [1:0] q
);

  logic [1:0] meta_reg;
  logic [1:0] q_reg;

  // two stages; only q_reg reads meta_reg, idle line level after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= `MSEB_LINE_IDLE;
      q_reg    <= `MSEB_LINE_IDLE;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// ==== rtl/mseb_ee_hs.sv ====
`timescale 1ns/10ps
`include "mseb_defines.svh"

module mseb_ee_hs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic        start_wr,
  input  wire logic [15:0] start_addr,
  input  wire logic [7:0]  start_data,
  input  wire logic        ee_internal_busy,
  input  wire logic        ee_done,
  input  wire logic [7:0]  ee_rdata,
  output wire logic        ee_req,
  output wire logic        ee_write,
  output wire logic [15:0] ee_addr,
  output wire logic [7:0]  ee_wdata,
  output wire logic        busy,
  output wire logic [7:0]  rd_byte,
  output wire logic        rd_valid
);

  logic        req_reg;
  logic        wr_reg;
  logic [15:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  rbyte_reg;
  logic        rval_reg;

  // busy covers our own request and any engine-started operation
  assign busy = req_reg | ee_internal_busy;
  wire   take = start & ~busy;
  wire   fin  = req_reg & ee_done;

  // one byte per request; new starts are dropped while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_reg <= 1'b0;
      rval_reg <= 1'b0;
    end else begin
      req_reg  <= take | (req_reg & ~ee_done);
      rval_reg <= fin & ~wr_reg;
    end
  end

  // request payload frozen while the engine works on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_reg    <= 1'b0;
      addr_reg  <= 16'h0000;
      wdata_reg <= 8'h00;
      rbyte_reg <= 8'h00;
    end else begin
      if (take) begin
        wr_reg    <= start_wr;
        addr_reg  <= start_addr;
        wdata_reg <= start_data;
      end
      if (fin && !wr_reg)
        rbyte_reg <= ee_rdata;
    end
  end

  assign ee_req   = req_reg;
  assign ee_write = wr_reg;
  assign ee_addr  = addr_reg;
  assign ee_wdata = wdata_reg;
  assign rd_byte  = rbyte_reg;
  assign rd_valid = rval_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  busy_block_a: assert property (start && busy |=> $stable(addr_reg) && $stable(wr_reg))
    else $error("start accepted while busy");
  single_byte_a: assert property (ee_req && !ee_done |=> ee_req && $stable(ee_addr))
    else $error("request dropped or moved before done");
  rd_return_a: assert property (fin && !wr_reg |=> rd_valid && rd_byte == $past(ee_rdata))
    else $error("read byte not returned");
  ee_rd_c: cover property (take && !start_wr ##[1:50] rd_valid);

endmodule

// ==== tb/mseb_ee_model.sv ====
`timescale 1ns/10ps

module mseb_ee_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ee_req,
  input  wire logic        ee_write,
  input  wire logic [15:0] ee_addr,
  input  wire logic [7:0]  ee_wdata,
  input  wire logic [15:0] lat,
  output logic             ee_done,
  output logic [7:0]       ee_rdata
);
  logic [7:0] mem [0:65535];
  int         cnt;
  int         n_req;

  initial begin
    ee_done = 1'b0;
    ee_rdata = 8'h00;
  end

  // one byte per request after lat cycles; idle data keeps toggling
  always @(posedge aclk) begin
    ee_done <= 1'b0;
    ee_rdata <= ~ee_rdata;
    if (!aresetn) begin
      cnt <= 0;
      n_req <= 0;
    end else if (ee_req && !ee_done && cnt >= lat) begin
      ee_done <= 1'b1;
      cnt <= 0;
      n_req <= n_req + 1;
      if (ee_write) mem[ee_addr] <= ee_wdata;
      else ee_rdata <= mem[ee_addr];
    end else if (ee_req && !ee_done) cnt <= cnt + 1;
  end
endmodule

// ==== tb/mseb_bridge_bench.sv ====
`timescale 1ns/10ps
`include "mseb_defines.svh"

module mseb_bridge_bench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        mdc, m_o, m_oe, ee_busy, present, oe_seen;
  logic [31:0] awaddr, wdata, araddr, seed;
  logic [3:0]  wstrb;
  logic [15:0] lat;
  wire logic   awready, wready, bvalid, arready, rvalid, mdio_o, mdio_oe;
  wire logic   ee_req, ee_write, ee_done, line;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] ee_addr;
  wire logic [7:0]  ee_wdata, ee_rdata;
  int          fails = 0, n_compared = 0, cyc = 0, frames, phy, last_reg;
  int          ee_m [int];

  // pull-up wins when nobody drives
  assign line = mdio_oe ? mdio_o : (m_oe ? m_o : 1'b1);

  mseb_bridge dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mdc(mdc), .mdio_i(line), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .ee_req(ee_req), .ee_write(ee_write), .ee_addr(ee_addr),
    .ee_wdata(ee_wdata), .ee_done(ee_done), .ee_rdata(ee_rdata),
    .ee_internal_busy(ee_busy), .eeprom_present(present));

  mseb_ee_model ee (.aclk(aclk), .aresetn(aresetn), .ee_req(ee_req),
    .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .lat(lat),
    .ee_done(ee_done), .ee_rdata(ee_rdata));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // hang guard, about twice the expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (mdio_oe) oe_seen <= 1'b1;
    if (cyc == 60000) begin
      fails++;
      tally_and_finish;
    end
  end

  function automatic logic [31:0] xs;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // both halves offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // master changes data while mdc low, samples just before the rise
  task automatic mbit(input logic b, input logic drv, output logic s);
    repeat (4) @(posedge aclk);
    mdc <= 1'b0;
    m_o <= b;
    m_oe <= drv;
    repeat (4) @(posedge aclk);
    s = line;
    mdc <= 1'b1;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic        s, t1, t2, rdf, ours;
    rdf = (op == `MSEB_OP_RD);
    ours = (pa == phy[4:0]);
    f = {2'b01, op, pa, ra, 2'b10, wd};
    oe_seen = 1'b0;
    if (xs() & 1) repeat (32) mbit(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      mbit(f[i], !(rdf && i < 18), s);
      if (i == 17) t1 = s;
      if (i == 16) t2 = s;
      if (i < 16) rd[i] = s;
    end
    repeat (4) @(posedge aclk);
    mdc <= 1'b0;
    m_oe <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("idle_oe", 32'h0, mdio_oe);
    if (ours && (op == `MSEB_OP_RD || op == `MSEB_OP_WR)) begin
      frames++;
      last_reg = ra;
    end
    if (rdf && ours) begin
      chk("ta1", 32'h1, t1);
      chk("ta2", 32'h0, t2);
      chk("rd_oe", 32'h1, oe_seen);
    end else chk("no_oe", 32'h0, oe_seen);
  endtask

  task automatic mwr(input logic [4:0] ra, input logic [15:0] v);
    logic [15:0] d;
    frame(`MSEB_OP_WR, phy[4:0], ra, v, d);
  endtask

  task automatic mrd(input logic [4:0] ra, output logic [15:0] d);
    frame(`MSEB_OP_RD, phy[4:0], ra, 16'h0000, d);
  endtask

  task automatic poll_idle;
    logic [15:0] d;
    int          n;
    n = 0;
    do begin
      mrd(`MSEB_RA_EECTL, d);
      n++;
    end while (d[15] !== 1'b0 && n < 20);
    chk("busy", 32'h0, d[15]);
  endtask

  task automatic ee_setup(input logic [15:0] a);
    mwr(`MSEB_RA_MMDCTL, 16'h001E);
    mwr(`MSEB_RA_MMDAD, a);
    mwr(`MSEB_RA_MMDCTL, 16'h401E);
  endtask

  initial begin
    logic [15:0] d, a;
    logic [31:0] r32;
    logic [1:0]  rs;
    logic [7:0]  b;
    int          n0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, mdc, m_oe, ee_busy} = 8'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'h0;
    m_o = 1'b1;
    present = 1'b1;
    lat = 16'h0;
    seed = 32'h6DE8;
    {frames, phy, last_reg} = 96'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(`MSEB_AX_CTRL, r32, rs);
    chk("ctrl_rst", 32'h0, r32);
    chk_resp("ctrl_rst", `MSEB_RESP_OK, rs);
    axi_rd(32'h0000_0040, r32, rs);
    chk("unmap_rd", 32'h0, r32);
    chk_resp("unmap_rd", `MSEB_RESP_ERR, rs);
    axi_wr(32'h0000_0040, 32'hFFFF_FFFF, rs);
    chk_resp("unmap_wr", `MSEB_RESP_ERR, rs);
    axi_wr(`MSEB_AX_STAT, 32'hFFFF_FFFF, rs);
    chk_resp("stat_wr", `MSEB_RESP_OK, rs);
    phy = (xs() % 31) + 1;
    axi_wr(`MSEB_AX_CTRL, phy, rs);
    axi_rd(`MSEB_AX_CTRL, r32, rs);
    chk("ctrl_rb", phy, r32);
    // foreign address and unused opcodes are ignored
    frame(`MSEB_OP_RD, phy[4:0] ^ 5'h0A, `MSEB_RA_EECTL, 16'h0000, d);
    chk("other_phy", 32'h0000_FFFF, d);
    n0 = ee.n_req;
    frame(2'h0, phy[4:0], `MSEB_RA_EECTL, 16'h8000, d);
    frame(2'h3, phy[4:0], `MSEB_RA_EECTL, 16'h8000, d);
    for (int p = 0; p < 2; p++) begin
      present <= p[0];
      mrd(`MSEB_RA_EECTL, d);
      chk("present", p, d[14]);
    end
    // engine busy on its own work blocks a start
    ee_busy <= 1'b1;
    mrd(`MSEB_RA_EECTL, d);
    chk("int_busy", 32'h1, d[15]);
    mwr(`MSEB_RA_EECTL, 16'h8000);
    ee_busy <= 1'b0;
    poll_idle;
    chk("dropped", n0, ee.n_req);
    for (int i = 0; i < 4; i++) begin
      a = 16'(xs());
      b = 8'(xs());
      lat <= i[0] ? 16'h02BC : 16'h0000;
      n0 = ee.n_req;
      poll_idle;
      ee_setup(a);
      mwr(`MSEB_RA_MMDAD, {8'h00, b});
      mwr(`MSEB_RA_EECTL, 16'h8001);
      ee_m[a] = b;
      poll_idle;
      ee_setup(a);
      mwr(`MSEB_RA_EECTL, 16'h8000);
      poll_idle;
      mrd(`MSEB_RA_MMDAD, d);
      chk("ee_byte", ee_m[a], d[7:0]);
      chk("one_byte", n0 + 2, ee.n_req);
    end
    mwr(5'h05, 16'hFFFF);
    mrd(5'h05, d);
    chk("unused_reg", 32'h0, d);
    axi_rd(`MSEB_AX_STAT, r32, rs);
    chk("status", (last_reg << 8) | 32'h2, r32);
    axi_rd(`MSEB_AX_FRMS, r32, rs);
    chk("frames", frames, r32);
    tally_and_finish;
  end
endmodule
